// [logic/ext_mem_regs.svh]
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the external memory interface files
`ifndef EXT_MEM_REGS_SVH
`define EXT_MEM_REGS_SVH

`define EXT_MEM_CONFIG_ADDR   8'hc7
`define EXT_MEM_PAGE_ADDR     8'haa
`define EXT_MEM_TIMING_ADDR   8'hf7
`define EXT_MEM_CONFIG_RESET  8'h03
`define EXT_MEM_PAGE_RESET    8'h00
`define EXT_MEM_TIMING_RESET  8'hff
`define CFG_MUX_BIT           4
`define CFG_REGION_HI         3
`define CFG_REGION_LO         2
`define CFG_LATCH_HI          1
`define CFG_LATCH_LO          0
`define TC_SETUP_HI           7
`define TC_SETUP_LO           6
`define TC_STROBE_HI          5
`define TC_STROBE_LO          2
`define TC_HOLD_HI            1
`define TC_HOLD_LO            0
`define ONCHIP_RAM_SIZE       17'h0_0400
`define ONCHIP_ADDR_MASK      16'h03ff
`define ACCESS_OVERHEAD       4'h4

`endif

// [logic/ext_mem_pkg.sv]
// Types shared by the external memory interface
// Assumes nothing of its surroundings
package ext_mem_pkg;

  typedef enum logic [1:0] {
    REGION_INTERNAL   = 2'b00,
    REGION_SPLIT      = 2'b01,
    REGION_SPLIT_BANK = 2'b10,
    REGION_EXTERNAL   = 2'b11
  } region_type;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_LATCH_H = 3'b001,
    ST_LATCH_L = 3'b010,
    ST_SETUP   = 3'b011,
    ST_STROBE  = 3'b100,
    ST_HOLD    = 3'b101,
    ST_FINISH  = 3'b110
  } phase_type;

endpackage

// [logic/ext_mem_sequencer.sv]
// Off-chip strobe sequencer: latch, setup, strobe, hold, finish phases
// Assumes a start pulse only while done is not pending and timing held stable
`include "ext_mem_regs.svh"
`timescale 1ns/100ps

module ext_mem_sequencer (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  // Control
  input  wire logic        start_i,
  input  wire logic        write_i,
  input  wire logic        mux_mode_i,
  input  wire logic [1:0]  latch_width_i,
  input  wire logic [1:0]  setup_i,
  input  wire logic [3:0]  strobe_i,
  input  wire logic [1:0]  hold_i,
  // Phase outputs
  output logic             busy_o,
  output logic             latch_o,
  output logic             addr_phase_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic             capture_o,
  output logic             done_o
);

  ext_mem_pkg::phase_type state_q;
  ext_mem_pkg::phase_type state_d;
  logic [4:0]             cnt_q;
  logic [4:0]             cnt_d;
  logic                   write_q;
  logic                   last_w;

  // Counter holds remaining cycles of the current phase minus one
  assign last_w = (cnt_q == 5'h00);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q - 5'h01;
    case (state_q)
      ext_mem_pkg::ST_IDLE: begin
        cnt_d = 5'h00;
        // R14: latch phase first
        if (start_i && !mux_mode_i) begin
          state_d = ext_mem_pkg::ST_LATCH_H;
          cnt_d   = {3'b000, latch_width_i};
        end else if (start_i) begin
          state_d = ext_mem_pkg::ST_SETUP;
          cnt_d   = {3'b000, setup_i};
        end
      end
      ext_mem_pkg::ST_LATCH_H: begin
        if (last_w) begin
          state_d = ext_mem_pkg::ST_LATCH_L;
          cnt_d   = {3'b000, latch_width_i};
        end
      end
      ext_mem_pkg::ST_LATCH_L: begin
        if (last_w) begin
          state_d = ext_mem_pkg::ST_SETUP;
          cnt_d   = {3'b000, setup_i};
        end
      end
      ext_mem_pkg::ST_SETUP: begin
        if (last_w) begin
          state_d = ext_mem_pkg::ST_STROBE;
          cnt_d   = {1'b0, strobe_i};
        end
      end
      ext_mem_pkg::ST_STROBE: begin
        if (last_w) begin
          state_d = ext_mem_pkg::ST_HOLD;
          cnt_d   = {3'b000, hold_i};
        end
      end
      ext_mem_pkg::ST_HOLD: begin
        if (last_w) begin
          state_d = ext_mem_pkg::ST_FINISH;
          cnt_d   = 5'h00;
        end
      end
      ext_mem_pkg::ST_FINISH: begin
        state_d = ext_mem_pkg::ST_IDLE;
        cnt_d   = 5'h00;
      end
      default: begin
        state_d = ext_mem_pkg::ST_IDLE;
        cnt_d   = 5'h00;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ext_mem_pkg::ST_IDLE;
      cnt_q   <= 5'h00;
      write_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      if (start_i && state_q == ext_mem_pkg::ST_IDLE) begin
        write_q <= write_i;
      end
    end
  end

  assign busy_o       = (state_q != ext_mem_pkg::ST_IDLE);
  assign latch_o      = (state_q == ext_mem_pkg::ST_LATCH_H);
  assign addr_phase_o = (state_q == ext_mem_pkg::ST_LATCH_H) ||
                        (state_q == ext_mem_pkg::ST_LATCH_L);
  assign rd_n_o       = !((state_q == ext_mem_pkg::ST_STROBE) && !write_q);
  assign wr_n_o       = !((state_q == ext_mem_pkg::ST_STROBE) && write_q);
  // Read data sampled on the last strobe cycle, while the strobe is still low
  assign capture_o    = (state_q == ext_mem_pkg::ST_STROBE) && last_w && !write_q;
  assign done_o       = (state_q == ext_mem_pkg::ST_FINISH);

endmodule

// [logic/ext_mem_interface.sv]
// External data memory interface: routes core data moves on-chip or off-chip
// Assumes a core that holds its request until done and an on-chip RAM beside it
//
// Summary of operation
// R1: Bank-select split: addresses below on-chip size go inside, above go off-chip.
// R2: Bank-select 8-bit move: page register gives high byte, index register low byte.
// R3: Bank-select 8-bit move decides inside or outside by page as high byte.
// R4: Bank-select 16-bit move decides by data pointer, drives all sixteen lines.
// R5: External-only mode sends every move off-chip; on-chip RAM is hidden.
// R6: External-only 8-bit move ignores page and leaves upper lines undriven.
// R7: External-only 8-bit move puts index register on lower address lines.
// R8: External-only 16-bit move drives data pointer on all sixteen lines.
// R9: Split without bank select: 8-bit off-chip move leaves upper lines undriven.
// R10: Non-multiplexed mode uses separate data and address pins.
// R11: Setup, hold, strobe and latch widths programmable in clock periods.
// R12: Off-chip access lasts programmed timing sum plus four cycles.
// R13: Minimum non-multiplexed access is five cycles with one-cycle strobe.
// R14: Multiplexed latch phase adds at least two cycles.
// R15: Setup and hold reset to their largest settings.
// R16: Mux bit 0 multiplexes, 1 separates; region 00 internal, 01 plain split.
// R17: Latch width field sets both latch phases to one to four cycles.
// R18: Software loads an off-chip page before plain split off-chip moves.
`include "ext_mem_regs.svh"
`timescale 1ns/100ps

module ext_mem_interface (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  // Special register port
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output logic      [7:0]  sfr_rdata_o,
  // Core data move request
  input  wire logic        move_req_i,
  input  wire logic        move_write_i,
  input  wire logic        move_wide_i,
  input  wire logic [15:0] data_pointer_i,
  input  wire logic [7:0]  index_reg_i,
  input  wire logic [7:0]  move_wdata_i,
  output logic      [7:0]  move_rdata_o,
  output logic             move_done_o,
  // On-chip data RAM
  output logic             ram_en_o,
  output logic             ram_we_o,
  output logic      [9:0]  ram_addr_o,
  output logic      [7:0]  ram_wdata_o,
  input  wire logic [7:0]  ram_rdata_i,
  // Off-chip bus
  output logic      [15:8] addr_hi_o,
  output logic             addr_hi_oe_o,
  output logic      [7:0]  addr_lo_o,
  output logic             addr_lo_oe_o,
  output logic      [7:0]  data_o,
  output logic             data_oe_o,
  input  wire logic [7:0]  data_i,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic             latch_o
);

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [4:0]  config_q;
  logic [7:0]  page_q;
  logic [7:0]  timing_q;
  logic        mux_sel_w;
  logic [1:0]  latch_w;
  ext_mem_pkg::region_type region_w;

  assign mux_sel_w = config_q[`CFG_MUX_BIT];
  assign region_w  = ext_mem_pkg::region_type'(config_q[`CFG_REGION_HI:`CFG_REGION_LO]);
  assign latch_w   = config_q[`CFG_LATCH_HI:`CFG_LATCH_LO];

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      config_q <= 5'(`EXT_MEM_CONFIG_RESET);
      page_q   <= `EXT_MEM_PAGE_RESET;
      // R15: largest setup and hold
      timing_q <= `EXT_MEM_TIMING_RESET;
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == `EXT_MEM_CONFIG_ADDR) begin
        config_q <= sfr_wdata_i[4:0];
      end
      if (sfr_addr_i == `EXT_MEM_PAGE_ADDR) begin
        page_q <= sfr_wdata_i;
      end
      if (sfr_addr_i == `EXT_MEM_TIMING_ADDR) begin
        timing_q <= sfr_wdata_i;
      end
    end
  end

  // Upper config bits read as zero
  assign sfr_rdata_o = (sfr_addr_i == `EXT_MEM_CONFIG_ADDR) ? {3'b000, config_q} :
                       (sfr_addr_i == `EXT_MEM_PAGE_ADDR)   ? page_q :
                       (sfr_addr_i == `EXT_MEM_TIMING_ADDR) ? timing_q : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Address formation and routing

  function automatic logic below_onchip(input logic [15:0] addr);
    below_onchip = ({1'b0, addr} < `ONCHIP_RAM_SIZE);
  endfunction

  logic [15:0] eff_addr_w;
  logic        go_inside_w;
  logic        drive_hi_w;

  // R2: page high byte with index low byte
  // R3: page takes part in the split decision
  // R6: external-only narrow move ignores page
  // R18: plain split relies on software page choice
  assign eff_addr_w = move_wide_i ? data_pointer_i : {page_q, index_reg_i};

  // R1: bank-select split by on-chip size
  // R4: wide move decides by data pointer
  // R5: external-only never goes inside
  // R16: region 00 always inside
  assign go_inside_w = (region_w == ext_mem_pkg::REGION_INTERNAL) ? 1'b1 :
                       (region_w == ext_mem_pkg::REGION_EXTERNAL) ? 1'b0 :
                       below_onchip(eff_addr_w);

  // R9: narrow moves in plain split and external-only leave upper lines to port
  // R8: wide moves drive all sixteen lines
  assign drive_hi_w = move_wide_i || (region_w == ext_mem_pkg::REGION_SPLIT_BANK);

  ////////////////////////////////////////////////////////////////////////
  // Access control

  logic        active_q;
  logic        inside_q;
  logic        hi_q;
  logic        write_q;
  logic [15:0] addr_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rdata_q;
  logic        done_q;
  logic        start_w;
  logic        seq_busy_w;
  logic        seq_latch_w;
  logic        seq_addr_w;
  logic        seq_rd_n_w;
  logic        seq_wr_n_w;
  logic        seq_cap_w;
  logic        seq_done_w;

  assign start_w = move_req_i && !active_q && !done_q;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      active_q <= 1'b0;
      inside_q <= 1'b0;
      hi_q     <= 1'b0;
      write_q  <= 1'b0;
      addr_q   <= 16'h0000;
      wdata_q  <= 8'h00;
      rdata_q  <= 8'h00;
      done_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start_w) begin
        active_q <= 1'b1;
        inside_q <= go_inside_w;
        hi_q     <= drive_hi_w;
        write_q  <= move_write_i;
        // R7: index register on lower lines
        addr_q   <= eff_addr_w;
        wdata_q  <= move_wdata_i;
      end else if (active_q && inside_q) begin
        active_q <= 1'b0;
        done_q   <= 1'b1;
        rdata_q  <= ram_rdata_i;
      end else if (active_q && seq_done_w) begin
        active_q <= 1'b0;
        done_q   <= 1'b1;
      end
      if (seq_cap_w) begin
        rdata_q <= data_i;
      end
    end
  end

  // On-chip RAM is read one cycle after the request is taken
  assign ram_en_o     = active_q && inside_q;
  assign ram_we_o     = active_q && inside_q && write_q;
  assign ram_addr_o   = 10'(addr_q & `ONCHIP_ADDR_MASK);
  assign ram_wdata_o  = wdata_q;
  assign move_rdata_o = rdata_q;
  assign move_done_o  = done_q;

  ////////////////////////////////////////////////////////////////////////
  // Off-chip sequencing

  logic ext_go_w;
  assign ext_go_w = start_w && !go_inside_w;

  // R11: latch, setup, strobe and hold widths from registers
  // R12: phases plus four overhead cycles
  // R13: single strobe cycle at minimum
  // R17: latch width applies to both phases
  ext_mem_sequencer u_seq (
    .ref_clk_i     (ref_clk_i),
    .sys_rst_i     (sys_rst_i),
    .start_i       (ext_go_w),
    .write_i       (move_write_i),
    .mux_mode_i    (mux_sel_w),
    .latch_width_i (latch_w),
    .setup_i       (timing_q[`TC_SETUP_HI:`TC_SETUP_LO]),
    .strobe_i      (timing_q[`TC_STROBE_HI:`TC_STROBE_LO]),
    .hold_i        (timing_q[`TC_HOLD_HI:`TC_HOLD_LO]),
    .busy_o        (seq_busy_w),
    .latch_o       (seq_latch_w),
    .addr_phase_o  (seq_addr_w),
    .rd_n_o        (seq_rd_n_w),
    .wr_n_o        (seq_wr_n_w),
    .capture_o     (seq_cap_w),
    .done_o        (seq_done_w)
  );

  logic ext_on_w;
  assign ext_on_w = seq_busy_w && !inside_q;

  // R10: separate pins when not multiplexed; low byte shares data in mux mode
  assign addr_hi_o    = addr_q[15:8];
  assign addr_hi_oe_o = ext_on_w && hi_q;
  assign addr_lo_o    = mux_sel_w ? addr_q[7:0] : (seq_addr_w ? addr_q[7:0] : wdata_q);
  assign addr_lo_oe_o = ext_on_w && (mux_sel_w || seq_addr_w || write_q);
  assign data_o       = wdata_q;
  assign data_oe_o    = ext_on_w && mux_sel_w && write_q;
  assign rd_n_o       = seq_rd_n_w;
  assign wr_n_o       = seq_wr_n_w;
  assign latch_o      = seq_latch_w;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_reset_timing: assert property (@(posedge ref_clk_i)
    $fell(sys_rst_i) |-> timing_q == 8'hff) else $error("timing not max after reset"); // R15
  a_bank_hi_drive: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (start_w && !go_inside_w && region_w == ext_mem_pkg::REGION_SPLIT_BANK)
    |=> addr_hi_oe_o && addr_hi_o == $past(eff_addr_w[15:8]))
    else $error("bank select high byte wrong"); // R2
  a_narrow_undriven: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (start_w && !move_wide_i && region_w != ext_mem_pkg::REGION_SPLIT_BANK)
    |=> !addr_hi_oe_o) else $error("upper lines driven"); // R6
  a_extonly_out: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (start_w && region_w == ext_mem_pkg::REGION_EXTERNAL) |=> !ram_en_o)
    else $error("on-chip used in external-only"); // R5
  a_internal_in: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (start_w && region_w == ext_mem_pkg::REGION_INTERNAL) |=> ram_en_o ##1 move_done_o)
    else $error("internal move not inside"); // R16
  a_split_bound: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (start_w && region_w == ext_mem_pkg::REGION_SPLIT_BANK && move_wide_i
     && data_pointer_i >= 16'h0400) |=> !ram_en_o)
    else $error("above boundary went inside"); // R1
  a_min_access: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (ext_go_w && mux_sel_w && timing_q == 8'h00) |=> seq_busy_w [*4] ##1 move_done_o)
    else $error("minimum access not five cycles"); // R13
  a_mux_latch: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (ext_go_w && !mux_sel_w) |=> latch_o ##1 seq_addr_w)
    else $error("latch phase missing"); // R14
  a_one_strobe: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !(rd_n_o == 1'b0 && wr_n_o == 1'b0)) else $error("both strobes low"); // R11

  c_inside_move: cover property (@(posedge ref_clk_i) start_w && go_inside_w);
  c_ext_read:    cover property (@(posedge ref_clk_i) seq_cap_w);
  c_ext_write:   cover property (@(posedge ref_clk_i) !wr_n_o);
  c_mux_access:  cover property (@(posedge ref_clk_i) latch_o);

endmodule

// [test/ext_sram_model.sv]
// Behavioural off-chip asynchronous SRAM facing the external memory interface
// Assumes strobes active low, latch active high, upper lines undriven when oe is low
`timescale 1ns/100ps

module ext_sram_model #(
  parameter logic [7:0] PORT_HI = 8'h5a
) (
  // Off-chip bus from the interface
  input  wire logic [15:8] addr_hi_i,
  input  wire logic        addr_hi_oe_i,
  input  wire logic [7:0]  addr_lo_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        muxed_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        latch_i,
  // Read data back and last address decoded
  output logic      [7:0]  rdata_o,
  output logic      [15:0] last_addr_o
);
  logic [7:0]  mem [65536];
  logic [7:0]  lo_latch_q = 8'h00;
  logic [7:0]  held_q = 8'h00;
  logic [15:0] cur_addr;

  ////////////////////////////////////////////////////////////////////////
  // Undriven upper lines settle at the port latch level
  assign cur_addr = {(addr_hi_oe_i === 1'b1) ? addr_hi_i : PORT_HI,
                     muxed_i ? lo_latch_q : addr_lo_i};
  // Released bus shows inverse of last value, never a stale match
  assign rdata_o = (rd_n_i === 1'b0) ? mem[cur_addr] : ~held_q;

  always @(negedge latch_i) begin
    lo_latch_q <= addr_lo_i;
  end

  always @(posedge rd_n_i) begin
    held_q <= mem[cur_addr];
  end

  always @(negedge rd_n_i or negedge wr_n_i) begin
    last_addr_o <= cur_addr;
  end

  // Muxed mode shares the low lines for write data
  always @(posedge wr_n_i) begin
    mem[cur_addr] <= muxed_i ? addr_lo_i : wdata_i;
  end
endmodule

// [test/test_external_data_memory_interface.sv]
// Self-checking bench for the external data memory interface
// Assumes an SRAM model on the off-chip bus and a bench-held on-chip RAM
`include "ext_mem_regs.svh"
`timescale 1ns/100ps

module test_external_data_memory_interface;
  localparam logic [7:0] PORT_HI = 8'h5a;
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  sfr_addr_i = 8'h00;
  logic        sfr_wr_i = 1'b0;
  logic [7:0]  sfr_wdata_i = 8'h00;
  logic [7:0]  sfr_rdata_o;
  logic        move_req_i = 1'b0;
  logic        move_write_i = 1'b0;
  logic        move_wide_i = 1'b0;
  logic [15:0] data_pointer_i = 16'h0000;
  logic [7:0]  index_reg_i = 8'h00;
  logic [7:0]  move_wdata_i = 8'h00;
  logic [7:0]  move_rdata_o, ram_wdata_o, ram_rdata_i;
  logic        move_done_o, ram_en_o, ram_we_o, addr_hi_oe_o, addr_lo_oe_o;
  logic [9:0]  ram_addr_o;
  logic [15:8] addr_hi_o;
  logic [7:0]  addr_lo_o, data_o, data_i;
  logic        data_oe_o, rd_n_o, wr_n_o, latch_o;
  logic [15:0] last_addr;
  logic [7:0]  cfg_sh = 8'h03;
  logic [7:0]  ram [1024];
  logic [7:0]  rv;
  int          error_cnt = 0, n_checks = 0, cyc;
  int          rd_cnt = 0, wr_cnt = 0, lat_cnt = 0, ram_cnt = 0, hi_cnt = 0, oe_cnt = 0;
  int          d_rd, d_wr, d_lat, d_ram, d_hi, d_oe;

  ext_mem_interface ext_mem_interface_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .move_req_i(move_req_i), .move_write_i(move_write_i),
    .move_wide_i(move_wide_i), .data_pointer_i(data_pointer_i), .index_reg_i(index_reg_i),
    .move_wdata_i(move_wdata_i), .move_rdata_o(move_rdata_o), .move_done_o(move_done_o),
    .ram_en_o(ram_en_o), .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o),
    .ram_wdata_o(ram_wdata_o), .ram_rdata_i(ram_rdata_i), .addr_hi_o(addr_hi_o),
    .addr_hi_oe_o(addr_hi_oe_o), .addr_lo_o(addr_lo_o), .addr_lo_oe_o(addr_lo_oe_o),
    .data_o(data_o), .data_oe_o(data_oe_o), .data_i(data_i), .rd_n_o(rd_n_o),
    .wr_n_o(wr_n_o), .latch_o(latch_o));

  ext_sram_model #(.PORT_HI(PORT_HI)) ext_sram_model_i (.addr_hi_i(addr_hi_o),
    .addr_hi_oe_i(addr_hi_oe_o), .addr_lo_i(addr_lo_o), .wdata_i(data_o),
    .muxed_i(cfg_sh[`CFG_MUX_BIT] === 1'b0), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
    .latch_i(latch_o), .rdata_o(data_i), .last_addr_o(last_addr));

  ////////////////////////////////////////////////////////////////////////
  initial forever #2 ref_clk_i = ~ref_clk_i;

  assign ram_rdata_i = ram[ram_addr_o];

  // Cumulative pin activity, differenced per move
  always @(posedge ref_clk_i) begin
    if (ram_en_o && ram_we_o) ram[ram_addr_o] <= ram_wdata_o;
    rd_cnt  <= rd_cnt + int'(rd_n_o === 1'b0);
    wr_cnt  <= wr_cnt + int'(wr_n_o === 1'b0);
    lat_cnt <= lat_cnt + int'(latch_o === 1'b1);
    ram_cnt <= ram_cnt + int'(ram_en_o === 1'b1);
    hi_cnt  <= hi_cnt + int'(addr_hi_oe_o === 1'b1);
    oe_cnt  <= oe_cnt + int'(data_oe_o === 1'b1);
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    if (a == `EXT_MEM_CONFIG_ADDR) cfg_sh <= d;
    @(posedge ref_clk_i);
    sfr_wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    @(posedge ref_clk_i);
    d = sfr_rdata_o;
  endtask

  // Request held until done; cyc counts take edge to done cycle
  task automatic move(input logic wide, input logic wr, input logic [15:0] dp,
                      input logic [7:0] idx, input logic [7:0] wd);
    int s_rd, s_wr, s_lat, s_ram, s_hi, s_oe, n;
    @(posedge ref_clk_i);
    s_rd = rd_cnt;
    s_wr = wr_cnt;
    s_lat = lat_cnt;
    s_ram = ram_cnt;
    s_hi = hi_cnt;
    s_oe = oe_cnt;
    move_req_i <= 1'b1;
    move_wide_i <= wide;
    move_write_i <= wr;
    data_pointer_i <= dp;
    index_reg_i <= idx;
    move_wdata_i <= wd;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (move_done_o !== 1'b1 && n < 300);
    if (n >= 300) begin
      error_cnt++;
      summarize();
    end
    move_req_i <= 1'b0;
    rv = move_rdata_o;
    cyc = n - 1;
    d_rd = rd_cnt - s_rd;
    d_wr = wr_cnt - s_wr;
    d_lat = lat_cnt - s_lat;
    d_ram = ram_cnt - s_ram;
    d_hi = hi_cnt - s_hi;
    d_oe = oe_cnt - s_oe;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_regs();
    reg_rd(`EXT_MEM_CONFIG_ADDR, rv);
    chk("config reset", 16'(rv), 16'h0003);
    reg_rd(`EXT_MEM_TIMING_ADDR, rv);
    chk("timing reset", 16'(rv), 16'h00ff);
    reg_rd(`EXT_MEM_PAGE_ADDR, rv);
    chk("page reset", 16'(rv), 16'h0000);
    reg_rd(8'h00, rv);
    chk("unmapped read", 16'(rv), 16'h0000);
    reg_wr(`EXT_MEM_CONFIG_ADDR, 8'hff);
    reg_rd(`EXT_MEM_CONFIG_ADDR, rv);
    chk("config unused bits", 16'(rv), 16'h001f);
  endtask

  task automatic t_external_only();
    reg_wr(`EXT_MEM_CONFIG_ADDR, 8'h1c);
    move(1'b1, 1'b1, 16'h0010, 8'h00, 8'h3c);
    chk("default access cycles", 16'(cyc), 16'd26);
    chk("default strobe width", 16'(d_wr), 16'd16);
    chk("low addr stays off-chip", 16'(d_ram), 16'd0);
    chk("wide address", last_addr, 16'h0010);
    reg_wr(`EXT_MEM_TIMING_ADDR, 8'h00);
    move(1'b1, 1'b0, 16'h0010, 8'h00, 8'h00);
    chk("minimum cycles", 16'(cyc), 16'd5);
    chk("minimum strobe", 16'(d_rd), 16'd1);
    chk("read data pins idle", 16'(d_oe), 16'd0);
    chk("off-chip read data", 16'(rv), 16'h003c);
    reg_wr(`EXT_MEM_PAGE_ADDR, 8'h77);
    move(1'b1, 1'b1, {PORT_HI, 8'h23}, 8'h00, 8'h81);
    move(1'b0, 1'b0, 16'h0000, 8'h23, 8'h00);
    chk("index read data", 16'(rv), 16'h0081);
    chk("upper lines released", 16'(d_hi), 16'd0);
    chk("index address", last_addr, {PORT_HI, 8'h23});
    reg_wr(`EXT_MEM_TIMING_ADDR, 8'h4b);
    move(1'b1, 1'b1, 16'h0200, 8'h00, 8'h09);
    chk("programmed cycles", 16'(cyc), 16'd11);
    chk("programmed strobe", 16'(d_wr), 16'd3);
    chk("write data pins driven", 16'(d_oe), 16'd10);
    reg_wr(`EXT_MEM_TIMING_ADDR, 8'h00);
  endtask

  task automatic t_bank_select();
    reg_wr(`EXT_MEM_CONFIG_ADDR, 8'h18);
    reg_wr(`EXT_MEM_PAGE_ADDR, 8'h03);
    move(1'b0, 1'b1, 16'h0000, 8'hff, 8'h11);
    chk("page below boundary", 16'(d_ram), 16'd1);
    chk("on-chip cycles", 16'(cyc), 16'd2);
    reg_wr(`EXT_MEM_PAGE_ADDR, 8'h12);
    move(1'b0, 1'b1, 16'h0000, 8'h34, 8'h22);
    chk("page above boundary", 16'(d_ram), 16'd0);
    chk("page and index address", last_addr, 16'h1234);
    move(1'b1, 1'b1, 16'h0400, 8'h00, 8'h33);
    chk("boundary goes off-chip", last_addr, 16'h0400);
    move(1'b1, 1'b0, 16'h03ff, 8'h00, 8'h00);
    chk("last on-chip byte", 16'(rv), 16'h0011);
    chk("on-chip no strobe", 16'(d_rd), 16'd0);
  endtask

  task automatic t_plain_split();
    reg_wr(`EXT_MEM_CONFIG_ADDR, 8'h14);
    reg_wr(`EXT_MEM_PAGE_ADDR, 8'h20);
    move(1'b0, 1'b1, 16'h0000, 8'h40, 8'h44);
    chk("split upper released", 16'(d_hi), 16'd0);
    chk("split port address", last_addr, {PORT_HI, 8'h40});
    move(1'b1, 1'b0, 16'h0100, 8'h00, 8'h00);
    chk("split low on-chip", 16'(d_ram), 16'd1);
    reg_wr(`EXT_MEM_CONFIG_ADDR, 8'h10);
    move(1'b1, 1'b1, 16'h0405, 8'h00, 8'h55);
    move(1'b1, 1'b0, 16'h0005, 8'h00, 8'h00);
    chk("internal alias data", 16'(rv), 16'h0055);
    chk("internal no strobe", 16'(d_rd), 16'd0);
  endtask

  task automatic t_muxed();
    for (int l = 0; l < 4; l++) begin
      reg_wr(`EXT_MEM_CONFIG_ADDR, 8'h0c | 8'(l));
      move(1'b1, 1'b1, 16'h0a00 + 16'(l), 8'h00, 8'h60 + 8'(l));
      chk("muxed cycles", 16'(cyc), 16'(7 + 2 * l));
      chk("latch high width", 16'(d_lat), 16'(l + 1));
      chk("muxed data pins idle", 16'(d_oe), 16'd0);
      move(1'b1, 1'b0, 16'h0a00 + 16'(l), 8'h00, 8'h00);
      chk("muxed read data", 16'(rv), 16'h0060 + 16'(l));
      chk("muxed address", last_addr, 16'h0a00 + 16'(l));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_reset_regs();
    t_external_only();
    t_bank_select();
    t_plain_split();
    t_muxed();
    summarize();
  end
endmodule
